// ==== core/umaf_pkg.sv ====
package umaf_pkg;
   // ****************************************************************
   // Register map (byte addresses, one aligned word each)
   // ****************************************************************
   localparam logic [7:0] OFS_DATA = 8'h00;      // Receive read / transmit write
   localparam logic [7:0] OFS_CSA = 8'h04;       // serial_ctrl_status_a
   localparam logic [7:0] OFS_CTRL = 8'h08;      // Frame format and enables
   localparam logic [7:0] OFS_BAUD = 8'h0c;      // baud_divisor
   localparam logic [7:0] OFS_IRQ_STS = 8'h10;   // Sticky event bits, read only
   localparam logic [7:0] OFS_IRQ_EN = 8'h14;    // Event enables
   localparam logic [7:0] OFS_IRQ_CLR = 8'h18;   // Write one to clear, write only

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CSA_RXC = 7;      // rx_complete_flag
   localparam int CSA_TXC = 6;      // tx_complete_flag, write one clears
   localparam int CSA_TXE = 5;      // Transmit holding register empty
   localparam int CSA_FE = 4;       // Frame error of buffered character
   localparam int CSA_OVR = 3;      // Overrun
   localparam int CSA_PE = 2;       // Parity error
   localparam int CSA_DBL = 1;      // double_speed_select
   localparam int CSA_AFE = 0;      // address_filter_enable
   localparam int CTRL_SZ_LSB = 0;  // char_size_select, three bits
   localparam int CTRL_TWO_STOP = 3;
   localparam int CTRL_PAR_EN = 4;
   localparam int CTRL_PAR_ODD = 5;
   localparam int CTRL_RX_EN = 6;
   localparam int CTRL_TX_EN = 7;
   localparam int CTRL_RX9 = 8;     // rx_ninth_bit, read only
   localparam int CTRL_TX9 = 9;     // tx_ninth_bit
   localparam int IRQ_RX = 0;       // Character stored
   localparam int IRQ_TX = 1;       // Transmission complete
   localparam int IRQ_DROP = 2;     // Data frame discarded by filter
   localparam int IRQ_ADDR = 3;     // Address frame stored
   localparam int IRQ_W = 4;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [9:0] CTRL_RESET = 10'h006;   // Eight data bits, all off
   localparam logic [11:0] BAUD_RESET = 12'h000;

   // ****************************************************************
   // Sampling and frame constants
   // ****************************************************************
   localparam logic [4:0] SPB_NORMAL = 5'h10;  // 16 samples per bit
   localparam logic [4:0] SPB_DOUBLE = 5'h08;  // 8 samples per bit
   localparam logic [4:0] SF_NORMAL = 5'h08;   // First vote sample
   localparam logic [4:0] SF_DOUBLE = 5'h04;
   localparam logic [4:0] SM_NORMAL = 5'h09;   // Middle vote sample
   localparam logic [4:0] SM_DOUBLE = 5'h05;
   localparam logic [2:0] SZ_NINE = 3'h7;      // Nine-bit character code

   // Receive and transmit sequencers
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
      RX_PARITY = 5'h08, RX_STOP = 5'h10
   } umaf_rx_state_t;
   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
      TX_PARITY = 5'h08, TX_STOP = 5'h10
   } umaf_tx_state_t;

   // Data bits for a size code; reserved codes fall back to eight
   function automatic logic [3:0] umaf_char_bits(input logic [2:0] code);
      if (code == SZ_NINE) return 4'h9;
      if (code < 3'h4) return 4'h5 + {2'h0, code[1:0]};
      return 4'h8;
   endfunction : umaf_char_bits
endpackage : umaf_pkg

// ==== core/umaf_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1: Filter on: data frames never reach buffer
// R2: Five to eight bits: first stop gives type
// R3: Nine bits: ninth data bit gives type
// R4: Type one is address, zero is data
// R5: Transmitter ignores the filter bit entirely
// R6: Master sends nine-bit, ninth bit marks address
// R7: Slaves also set to nine-bit format
// R8: Stored address frame sets receive-complete normally
// R9: Addressed slave software clears filter bit
// R10: Unfiltered receiver accepts data; filtered ones discard
// R11: After last data, slave re-enables filter
// R12: Short formats: sender uses two stop bits
// R13: Avoid read-modify-write on filter bit location
// R14: Sixteen samples per bit, eight when doubled
// R15: Vote starts sample 8, or 4 doubled
// R16: Middle vote sample 9, or 5 doubled
// R17: Character plus parity spans 5 to 10
// R18: Bit is majority of three centre samples
// R19: Dropped frame leaves buffer, flags untouched
module umaf_top (
   // Clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic rxd,
   output logic txd,
   // Interrupt
   output logic irq
);
   import umaf_pkg::*;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [9:0] ctrl;               // Format and enables
   logic [11:0] baud_divisor;      // Sample tick divider
   logic address_filter_enable;
   logic double_speed_select;
   logic [IRQ_W-1:0] irq_status;   // Sticky events
   logic [IRQ_W-1:0] irq_enable;
   logic [7:0] rx_data;            // serial_data_buffer, receive side
   logic rx_ninth_bit;
   logic rx_complete_flag;
   logic rx_fe, rx_pe, rx_ovr;     // Errors of buffered character
   logic tx_complete_flag;
   logic [8:0] tx_hold;            // Holding register with tx_ninth_bit
   logic tx_empty;

   // Decoded fields
   logic [2:0] char_size_select;
   logic two_stop_select, par_en, par_odd, rx_en, tx_en, nine;
   logic [3:0] nbits;
   logic [4:0] spb, sf;
   assign char_size_select = ctrl[CTRL_SZ_LSB +: 3];
   assign two_stop_select = ctrl[CTRL_TWO_STOP];
   assign par_en = ctrl[CTRL_PAR_EN];
   assign par_odd = ctrl[CTRL_PAR_ODD];
   assign rx_en = ctrl[CTRL_RX_EN];
   assign tx_en = ctrl[CTRL_TX_EN];
   assign nine = (char_size_select == SZ_NINE);
   assign nbits = umaf_char_bits(char_size_select);
   assign spb = double_speed_select ? SPB_DOUBLE : SPB_NORMAL; // R14
   assign sf = double_speed_select ? SF_DOUBLE : SF_NORMAL; // R15

   // ****************************************************************
   // APB decode
   // ****************************************************************
   logic setup, wr, rd_data;
   logic mapped;
   logic [31:0] rd_mux;
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign rd_data = psel && penable && !pwrite && (paddr == OFS_DATA);
   assign pready = 1'b1; // Zero wait states
   assign mapped = (paddr == OFS_DATA) || (paddr == OFS_CSA) || (paddr == OFS_CTRL) ||
      (paddr == OFS_BAUD) || (paddr == OFS_IRQ_STS) || (paddr == OFS_IRQ_EN) ||
      (paddr == OFS_IRQ_CLR);

   // Read mux; write-only clear reads zero
   always_comb begin
      rd_mux = 32'h0;
      unique case (paddr)
         OFS_DATA: rd_mux = {24'h0, rx_data};
         OFS_CSA: rd_mux = {24'h0, rx_complete_flag, tx_complete_flag, tx_empty, rx_fe,
            rx_ovr, rx_pe, double_speed_select, address_filter_enable};
         OFS_CTRL: rd_mux = {22'h0, ctrl[9], rx_ninth_bit, ctrl[7:0]};
         OFS_BAUD: rd_mux = {20'h0, baud_divisor};
         OFS_IRQ_STS: rd_mux = {28'h0, irq_status};
         OFS_IRQ_EN: rd_mux = {28'h0, irq_enable};
         default: rd_mux = 32'h0;
      endcase
   end

   // Read data and error sampled in setup, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (ce && setup) begin
         prdata <= pwrite ? 32'h0 : rd_mux;
         pslverr <= !mapped;
      end
   end

   // Software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         baud_divisor <= BAUD_RESET;
         address_filter_enable <= 1'b0;
         double_speed_select <= 1'b0;
         irq_enable <= '0;
      end else if (ce && wr) begin
         if (paddr == OFS_CTRL) ctrl <= {pwdata[9], 1'b0, pwdata[7:0]};
         if (paddr == OFS_BAUD) baud_divisor <= pwdata[11:0];
         if (paddr == OFS_IRQ_EN) irq_enable <= pwdata[IRQ_W-1:0];
         // Filter bit shares this word with the W1C transmit flag
         if (paddr == OFS_CSA) begin
            address_filter_enable <= pwdata[CSA_AFE];
            double_speed_select <= pwdata[CSA_DBL];
         end
      end
   end

   // ****************************************************************
   // Sample tick
   // ****************************************************************
   logic [11:0] div_cnt;
   logic tick;
   assign tick = (div_cnt == 12'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_cnt <= 12'h0;
      else if (ce) div_cnt <= tick ? baud_divisor : div_cnt - 12'h1;
   end

   // ****************************************************************
   // Receiver
   // ****************************************************************
   umaf_rx_state_t rx_state;
   logic [4:0] smp;           // Sample number within bit, 1..spb
   logic [1:0] win;           // Earlier two vote samples
   logic [3:0] rx_idx;
   logic [8:0] rx_shift;
   logic rx_par;
   logic vote_strobe, vote_val, bit_end;
   logic frame_done, type_bit, accept, drop;

   function automatic logic majority(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : majority

   assign vote_strobe = tick && (rx_state != RX_IDLE) && (smp == sf + 5'h2); // R15 R16
   assign vote_val = majority({win, rxd}); // R18
   assign bit_end = tick && (smp == spb); // R14
   assign frame_done = vote_strobe && (rx_state == RX_STOP);
   assign type_bit = nine ? rx_shift[8] : vote_val; // R2 R3
   assign drop = frame_done && address_filter_enable && !type_bit; // R1 R4 R10
   assign accept = frame_done && !drop; // R8

   // Sequencer and sample counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= RX_IDLE;
         smp <= 5'h0;
         rx_idx <= 4'h0;
      end else if (ce) begin
         if (!rx_en) begin
            rx_state <= RX_IDLE;
         end else if (tick) begin
            smp <= (smp == spb) ? 5'h1 : smp + 5'h1; // R14
            unique case (rx_state)
               RX_IDLE: begin
                  // Falling edge found: this is sample one
                  if (!rxd) begin
                     rx_state <= RX_START;
                     smp <= 5'h2;
                     rx_idx <= 4'h0;
                  end
               end
               RX_START: begin
                  if (vote_strobe && vote_val) rx_state <= RX_IDLE; // Noise spike
                  else if (bit_end) rx_state <= RX_DATA;
               end
               RX_DATA: begin
                  if (bit_end) begin
                     rx_idx <= rx_idx + 4'h1;
                     // R17
                     if (rx_idx == nbits - 4'h1) rx_state <= par_en ? RX_PARITY : RX_STOP;
                  end
               end
               RX_PARITY: if (bit_end) rx_state <= RX_STOP;
               // Only the first stop bit; done at its vote for early restart
               RX_STOP: if (vote_strobe) rx_state <= RX_IDLE;
            endcase
         end
      end
   end

   // Vote window and bit assembly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win <= 2'h0;
         rx_shift <= 9'h0;
         rx_par <= 1'b0;
      end else if (ce && tick) begin
         if (smp >= sf && smp <= sf + 5'h1) win <= {win[0], rxd}; // R18
         if (rx_state == RX_START) begin
            rx_shift <= 9'h0; // Unused high bits read zero
            rx_par <= 1'b0;
         end
         if (vote_strobe && rx_state == RX_DATA) rx_shift[rx_idx] <= vote_val;
         if (vote_strobe && (rx_state == RX_DATA || rx_state == RX_PARITY))
            rx_par <= rx_par ^ vote_val;
      end
   end

   // Receive buffer; dropped frames leave every field alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data <= 8'h0;
         rx_ninth_bit <= 1'b0;
         rx_fe <= 1'b0;
         rx_pe <= 1'b0;
         rx_ovr <= 1'b0;
      end else if (ce) begin
         if (accept) begin // R19
            rx_data <= rx_shift[7:0];
            rx_ninth_bit <= nine ? rx_shift[8] : 1'b0;
            rx_fe <= !vote_val;
            rx_pe <= par_en && (rx_par != par_odd);
            rx_ovr <= rx_complete_flag && !rd_data;
         end else if (!rx_en) begin
            rx_fe <= 1'b0;
            rx_pe <= 1'b0;
            rx_ovr <= 1'b0;
         end
      end
   end

   // Receive complete: new character wins over a same-cycle read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rx_complete_flag <= 1'b0;
      else if (ce) begin
         if (accept) rx_complete_flag <= 1'b1; // R8
         else if (rd_data || !rx_en) rx_complete_flag <= 1'b0;
      end
   end

   // ****************************************************************
   // Transmitter, no path from the filter bit
   // ****************************************************************
   umaf_tx_state_t tx_state;
   logic [4:0] tsm;
   logic [3:0] tx_idx;
   logic [8:0] tx_sh;
   logic tx_par, tx_stop2, tbit_end, tx_done, tx_load;
   assign tbit_end = tick && (tsm == spb);
   assign tx_load = wr && (paddr == OFS_DATA) && tx_empty; // R5
   assign tx_done = tbit_end && (tx_state == TX_STOP) && (tx_stop2 || !two_stop_select);

   // Holding register; writes while full are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_hold <= 9'h0;
         tx_empty <= 1'b1;
      end else if (ce) begin
         if (tx_load) begin
            tx_hold <= {ctrl[CTRL_TX9], pwdata[7:0]};
            tx_empty <= 1'b0;
         end else if (tx_state == TX_IDLE && !tx_empty && tx_en) begin
            tx_empty <= 1'b1;
         end
      end
   end

   // Frame sequencer, R5
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= TX_IDLE;
         tsm <= 5'h1;
         tx_idx <= 4'h0;
         tx_sh <= 9'h0;
         tx_par <= 1'b0;
         tx_stop2 <= 1'b0;
      end else if (ce) begin
         unique case (tx_state)
            TX_IDLE: begin
               if (!tx_empty && tx_en) begin
                  tx_state <= TX_START;
                  tx_sh <= tx_hold;
                  tx_par <= par_odd;
                  tsm <= 5'h1;
               end
            end
            TX_START: if (tbit_end) begin
               tx_state <= TX_DATA;
               tx_idx <= 4'h0;
            end
            TX_DATA: if (tbit_end) begin
               tx_par <= tx_par ^ tx_sh[tx_idx];
               tx_idx <= tx_idx + 4'h1;
               if (tx_idx == nbits - 4'h1) begin
                  tx_state <= par_en ? TX_PARITY : TX_STOP;
                  tx_stop2 <= 1'b0;
               end
            end
            TX_PARITY: if (tbit_end) begin
               tx_state <= TX_STOP;
               tx_stop2 <= 1'b0;
            end
            TX_STOP: begin
               if (tx_done) tx_state <= TX_IDLE;
               else if (tbit_end) tx_stop2 <= 1'b1;
            end
         endcase
         if (tx_state != TX_IDLE && tick) tsm <= (tsm == spb) ? 5'h1 : tsm + 5'h1;
      end
   end

   // Registered line level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) txd <= 1'b1;
      else if (ce) begin
         unique case (tx_state)
            TX_IDLE: txd <= 1'b1;
            TX_START: txd <= 1'b0;
            TX_DATA: txd <= tx_sh[tx_idx];
            TX_PARITY: txd <= tx_par;
            TX_STOP: txd <= 1'b1;
         endcase
      end
   end

   // Transmit complete: set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tx_complete_flag <= 1'b0;
      else if (ce) begin
         if (tx_done && tx_empty && !tx_load) tx_complete_flag <= 1'b1;
         else if (wr && paddr == OFS_CSA && pwdata[CSA_TXC]) tx_complete_flag <= 1'b0;
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;
   logic [IRQ_W-1:0] next_irq_enable; // Enable as it stands after this edge
   assign ev = {accept && type_bit, drop, tx_done, accept};
   assign clr = (wr && paddr == OFS_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;
   // Same-edge enable write counts, so irq never lags its own mask
   assign next_irq_enable = (wr && paddr == OFS_IRQ_EN) ? pwdata[IRQ_W-1:0] : irq_enable;

   // Sticky bits; an event beats its clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         irq_status <= (irq_status & ~clr) | ev;
         irq <= |(((irq_status & ~clr) | ev) & next_irq_enable);
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   sequence s_drop;
      frame_done && address_filter_enable && !type_bit;
   endsequence
   sequence s_kept;
      frame_done && !(address_filter_enable && !type_bit);
   endsequence

   chk_drop_no_store: assert property (s_drop |=> $stable(rx_data) && $stable(rx_fe)) // R1
      else $error("Filtered data frame changed the buffer");
   chk_drop_no_flag: assert property (s_drop and !rx_complete_flag |=> !rx_complete_flag) // R19
      else $error("Filtered frame set receive complete");
   chk_addr_stored: assert property (s_kept |=> rx_complete_flag) // R8
      else $error("Accepted frame did not set receive complete");
   chk_ninth_kept: assert property (s_kept and nine |=> rx_ninth_bit == $past(rx_shift[8])) // R3
      else $error("Ninth bit not stored");
   chk_stop_type: assert property (frame_done && !nine && vote_val |-> !drop) // R2
      else $error("High first stop bit was treated as data");
   chk_type_data: assert property (frame_done && !type_bit && !address_filter_enable
      |=> rx_complete_flag) // R10
      else $error("Unfiltered data frame lost");
   chk_smp_range: assert property (rx_state != RX_IDLE |-> smp <= spb && smp != 5'h0) // R14
      else $error("Sample count out of range");
   chk_vote_point: assert property (vote_strobe |-> smp == (double_speed_select ?
      SM_DOUBLE : SM_NORMAL) + 5'h1) // R16
      else $error("Vote taken off centre");
   chk_start_reject: assert property (vote_strobe && rx_state == RX_START && vote_val
      |=> rx_state == RX_IDLE) // R18
      else $error("Noise start bit not rejected");
   chk_irq_level: assert property (irq == (|(irq_status & irq_enable)))
      else $error("Interrupt level differs from enabled status");
endmodule : umaf_top

// ==== testbench/umaf_ser_master.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Serial sender standing on the shared line
// ****************************************************************
module umaf_ser_master (
   // Clock
   input wire logic pclk,
   // Line toward the receiver
   output logic rxd
);
   // Line idles high, as a pulled-up bus would
   initial rxd = 1'b1;

   // Start, nb bits LSB first, type stop, then one extra stop
   // Glitch inverts the middle sample of one frame bit (-1 for none)
   task automatic send(input logic [8:0] d, input int nb, input logic stop1,
                       input int spb, input int glitch);
      logic [11:0] f;
      f = 12'hfff;
      f[0] = 1'b0;
      for (int i = 0; i < nb; i++) f[i + 1] = d[i];
      f[nb + 1] = stop1;
      // Second stop always sent, since the first carries the type
      for (int i = 0; i <= nb + 2; i++) begin
         for (int k = 1; k <= spb; k++) begin
            @(posedge pclk);
            rxd <= (i == glitch && k == spb / 2 + 1) ? ~f[i] : f[i];
         end
      end
   endtask : send
endmodule : umaf_ser_master

// ==== testbench/test_uart_multiprocessor_address_filter.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module test_uart_multiprocessor_address_filter;
   import umaf_pkg::*;
   // Bus master side
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic ce = 1'b1; // Freeze control
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   // Design outputs and serial line
   logic [31:0] prdata;
   logic pready, pslverr, rxd, txd, irq;
   // Expected read results, oldest first
   logic [32:0] expq[$];
   int bad_count = 0, compares = 0, cycles = 0;
   logic [7:0] rnd;
   logic [8:0] fr;

   always #25 pclk = ~pclk;

   umaf_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
      .irq(irq));
   umaf_ser_master u_ser (.pclk(pclk), .rxd(rxd));

   // Single comparison point
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test

   // Hang guard; a normal run takes under two thousand cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         stop_test();
      end
   end

   // Read watcher: takes the oldest note at each completed read
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         check({pslverr, prdata}, (expq.size() != 0) ? expq.pop_front() : 'x);
      end
   end

   // One bus transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Wait states end only by pready; the hang guard ends a dead bus
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
      expq.push_back({err, e});
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Level of irq, looked at away from the launching edge
   task automatic irq_is(input logic e);
      @(negedge pclk);
      check({32'h0, irq}, {32'h0, e});
      @(posedge pclk);
   endtask : irq_is

   // Samples eight bits of an outgoing frame at their centres
   task automatic tx_expect(input logic [7:0] b);
      while (txd !== 1'b0) @(posedge pclk);
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge pclk);
         check({32'h0, txd}, {32'h0, b[i]});
      end
      repeat (40) @(posedge pclk);
   endtask : tx_expect

   initial begin
      void'($urandom(47678));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped place
      rd(OFS_CSA, 32'h20);
      rd(OFS_CTRL, 32'h6);
      rd(8'h1c, 32'h0, 1'b1);
      // Nine-bit slave, one tick per pclk, filter on
      wr(OFS_BAUD, 32'h0);
      wr(OFS_IRQ_EN, 32'hf);
      wr(OFS_CTRL, 32'h47);
      wr(OFS_CSA, 32'h1);
      u_ser.send(9'h15a, 9, 1'b1, 16, -1);
      rd(OFS_CSA, 32'ha1);
      rd(OFS_CTRL, 32'h147);
      rd(OFS_IRQ_STS, 32'h9);
      irq_is(1'b1);
      rd(OFS_DATA, 32'h5a);
      // Data frame while filtering: nothing changes but the drop event
      rnd = 8'($urandom());
      u_ser.send({1'b0, rnd}, 9, 1'b1, 16, -1);
      rd(OFS_CSA, 32'h21);
      rd(OFS_IRQ_STS, 32'hd);
      rd(OFS_DATA, 32'h5a);
      rd(OFS_CTRL, 32'h147);
      // Mask, clear, unmask
      wr(OFS_IRQ_EN, 32'h0);
      irq_is(1'b0);
      wr(OFS_IRQ_CLR, 32'hf);
      wr(OFS_IRQ_EN, 32'hf);
      // Frozen block ignores a write
      ce <= 1'b0;
      wr(OFS_IRQ_EN, 32'h0);
      ce <= 1'b1;
      rd(OFS_IRQ_EN, 32'hf);
      irq_is(1'b0);
      rd(OFS_IRQ_STS, 32'h0);
      // Addressed: filter off, data accepted despite a glitched sample
      wr(OFS_CSA, 32'h0);
      rnd = 8'($urandom());
      u_ser.send({1'b0, rnd}, 9, 1'b1, 16, 4);
      rd(OFS_CSA, 32'ha0);
      rd(OFS_DATA, {24'h0, rnd});
      rd(OFS_CTRL, 32'h047);
      // Transfer over: filter back on, data ignored again
      wr(OFS_CSA, 32'h1);
      u_ser.send(9'h0c3, 9, 1'b1, 16, -1);
      rd(OFS_CSA, 32'h21);
      // Transmitter behaves the same with filter on and off
      wr(OFS_CTRL, 32'hc3);
      wr(OFS_DATA, 32'ha5);
      tx_expect(8'ha5);
      rd(OFS_CSA, 32'h61);
      wr(OFS_CSA, 32'h40);
      wr(OFS_DATA, 32'h3c);
      tx_expect(8'h3c);
      rd(OFS_IRQ_STS, 32'h7);
      // Eight-bit, double speed, filter on: first stop gives the type
      wr(OFS_CSA, 32'h43);
      u_ser.send(9'h0a5, 8, 1'b0, 8, -1);
      rd(OFS_CSA, 32'h23);
      rnd = 8'($urandom());
      u_ser.send({1'b0, rnd}, 8, 1'b1, 8, 2);
      rd(OFS_CSA, 32'ha3);
      rd(OFS_DATA, {24'h0, rnd});
      // Every short size with even parity appended
      for (int c = 0; c < 4; c++) begin
         wr(OFS_CTRL, 32'hd0 | c);
         rnd = 8'($urandom() & ((32'h1 << (c + 5)) - 32'h1));
         fr = {1'b0, rnd};
         fr[c + 5] = ^rnd;
         u_ser.send(fr, c + 6, 1'b1, 8, -1);
         rd(OFS_CSA, 32'ha3);
         rd(OFS_DATA, {24'h0, rnd});
      end
      repeat (4) @(posedge pclk);
      stop_test();
   end
endmodule : test_uart_multiprocessor_address_filter
